// >>> rtl/a4t_core.v
// transceiver core: host bus, control, rx FIFOs, labels, transmitter
`default_nettype none
`include "a4t_consts.vh"
module a4t_core #(
  parameter TICK_DIV = `A4T_TICK_DIV
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire [15:0] bus_in,
  output reg  [15:0] bus_out,
  output reg         bus_oe,
  input  wire        half_sel,
  input  wire        rx1_read_n,
  input  wire        rx2_read_n,
  input  wire        reg_read_n,
  input  wire        ctrl_write_n,
  input  wire        load_first_half_n,
  input  wire        load_second_half_n,
  input  wire        tx_go,
  input  wire        rate_check_off_n,
  input  wire        rx1_one_in,
  input  wire        rx1_zero_in,
  input  wire        rx2_one_in,
  input  wire        rx2_zero_in,
  output wire        rx1_ready_n,
  output wire        rx1_halfway_n,
  output wire        rx1_full_n,
  output wire        rx2_ready_n,
  output wire        rx2_halfway_n,
  output wire        rx2_full_n,
  output wire        tx_full_n,
  output wire        tx_halfway_n,
  output wire        tx_done,
  output reg         tx_ones_out,
  output reg         tx_zeros_out
);
  localparam I_SEL = 6;
  localparam I_RD1 = 7;
  localparam I_PL1 = 9;
  localparam I_RSR = 11;
  localparam I_CW  = 12;
  localparam I_GO  = 5;
  localparam I_NFD = 4;
  localparam [31:0] TICK_WIDE = TICK_DIV - 1;
  localparam [7:0]  TICK_LAST = TICK_WIDE[7:0];
  localparam TS_IDLE = 4'b0001;
  localparam TS_DATA = 4'b0010;
  localparam TS_NULL = 4'b0100;
  localparam TS_GAP  = 4'b1000;

  function [7:0] rev8;
    input [7:0] v;
    integer b;
    begin
      for (b = 0; b < 8; b = b + 1)
        rev8[b] = v[7 - b];
    end
  endfunction

  // word to bus half; index 0 of the word is serial bit 1
  function [15:0] map_half;
    input [31:0] w;
    input        second;
    input        order;
    begin
      if (order)
        map_half = second ? w[31:16] : w[15:0];
      else if (second)
        map_half = w[28:13];
      else
        map_half = {w[12:8], w[30], w[29], w[31], rev8(w[7:0])};
    end
  endfunction

  function [31:0] unmap;
    input [15:0] a;
    input [15:0] b;
    input        order;
    begin
      if (order)
        unmap = {b, a};
      else
        unmap = {a[8], a[10], a[9], b, a[15:11], rev8(a[7:0])};
    end
  endfunction

  function [31:0] add_par;
    input [31:0] w;
    input        on;
    input        even;
    begin
      add_par = w;
      if (on)
        add_par[31] = even ? ^w[30:0] : ~(^w[30:0]);
    end
  endfunction

  // input synchronisers; level at s2, edges from s2 against s3
  wire [12:0] asy = {ctrl_write_n, reg_read_n, load_second_half_n,
                     load_first_half_n, rx2_read_n, rx1_read_n, half_sel,
                     tx_go, rate_check_off_n, rx2_zero_in, rx2_one_in,
                     rx1_zero_in, rx1_one_in};
  reg  [12:0] s1;
  reg  [12:0] s2;
  reg  [12:0] s3;
  reg  [15:0] bus_s1;
  reg  [15:0] bus_s2;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1     <= `A4T_SYNC_RST;
      s2     <= `A4T_SYNC_RST;
      s3     <= `A4T_SYNC_RST;
      bus_s1 <= 16'h0000;
      bus_s2 <= 16'h0000;
    end else begin
      s1     <= asy;
      s2     <= s1;
      s3     <= s2;
      bus_s1 <= bus_in;
      bus_s2 <= bus_s1;
    end
  end
  wire [12:0] rise = s2 & ~s3;
  wire        sel  = s2[I_SEL];

  // master tick divider, then divide by 8 for low speed
  reg  [7:0] tick_cnt;
  reg  [2:0] lo_cnt;
  wire       tick = (tick_cnt == TICK_LAST);
  wire       slow = tick & (lo_cnt == `A4T_LO_LAST);
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt <= 8'h00;
      lo_cnt   <= 3'h0;
    end else begin
      tick_cnt <= tick ? 8'h00 : tick_cnt + 8'h01;
      if (tick)
        lo_cnt <= lo_cnt + 3'h1;
    end
  end

  // control word; reset value is fixed, host rewrites after reset
  reg  [15:0] ctrl_reg;
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      ctrl_reg <= `A4T_CTRL_RST;
    else if (rise[I_CW])
      ctrl_reg <= bus_s2;
  end
  wire lbl_mode = ctrl_reg[`A4T_CB_LBL] & sel;
  wire loop_on  = ~ctrl_reg[`A4T_CB_NOLOOP];

  // transmitter FIFO storage and counters
  reg  [31:0] tmem [0:31];
  reg  [4:0]  twp;
  reg  [4:0]  trp;
  reg  [5:0]  tcnt;
  reg  [15:0] half1_reg;
  reg         half1_ok;
  reg  [3:0]  tstate;
  reg  [31:0] tsh;
  reg  [4:0]  tbit;
  reg  [5:0]  tphase;
  wire tx_en   = ctrl_reg[`A4T_CB_TX_LO] ? slow : tick;
  wire t_full  = (tcnt == `A4T_DEPTH);
  wire t_push  = rise[I_PL1 + 1] & ~lbl_mode & half1_ok & ~t_full;
  // start only on a tx tick, else the first bit comes out short
  wire t_start = (tcnt != 6'h00) & tx_en &
                 ((tstate == TS_IDLE && s2[I_GO]) ||
                  (tstate == TS_GAP &&
                   tphase == `A4T_TX_GAP - 6'h01));
  wire t_pop   = t_start;

  // per receiver: line select, receiver, label memory, FIFO
  wire [1:0]  rdy;
  wire [1:0]  hlf;
  wire [1:0]  ful;
  wire [31:0] rxd;
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1) begin : g_rx
      reg  [7:0]  lbl [0:15];
      reg  [3:0]  lptr;
      reg  [31:0] mem [0:31];
      reg  [4:0]  wp;
      reg  [4:0]  rp;
      reg  [5:0]  cnt;
      wire [31:0] w;
      wire        stb;
      wire [15:0] m;
      wire        one_l;
      wire        zero_l;
      wire        lf = ctrl_reg[`A4T_CB_LF1 + i];
      wire        sf = i ? ctrl_reg[`A4T_CB_SF2] : ctrl_reg[`A4T_CB_SF1];
      wire [1:0]  sdi = i ? ctrl_reg[`A4T_CB_SF2 + 2:`A4T_CB_SF2 + 1]
                          : ctrl_reg[`A4T_CB_SF1 + 2:`A4T_CB_SF1 + 1];
      wire        full = (cnt == `A4T_DEPTH);
      wire        pop  = rise[I_RD1 + i] & sel & ~ctrl_reg[`A4T_CB_LBL] &
                         (cnt != 6'h00);
      wire        push;
      wire        push_new;
      genvar j;
      for (j = 0; j < 16; j = j + 1) begin : g_m
        assign m[j] = (lbl[j] == w[7:0]);
      end
      // self test feeds rx2 with the inverted transmitter output
      assign one_l  = loop_on ? (i ? tx_zeros_out : tx_ones_out) : s2[2 * i];
      assign zero_l = loop_on ? (i ? tx_ones_out : tx_zeros_out)
                              : s2[2 * i + 1];
      a4t_rx u_rx (
        .clk          (clk),
        .nrst         (nrst),
        .samp_en      (ctrl_reg[i ? `A4T_CB_RX2_LO : `A4T_CB_RX1_LO]
                       ? slow : tick),
        .rate_chk     (s2[I_NFD]),
        .suspend      (ctrl_reg[`A4T_CB_LBL]),
        .one_in       (one_l),
        .zero_in      (zero_l),
        .word_reg     (w),
        .word_stb_reg (stb)
      );
      assign push = stb & (~lf | (|m)) & (~sf | (w[9:8] == sdi));
      assign push_new = push & (~full | pop);
      always @(posedge clk) begin
        if (push && full && !pop)
          mem[wp - 5'h01] <= w;
        else if (push_new)
          mem[wp] <= w;
        if (lbl_mode && rise[I_PL1 + i])
          lbl[lptr] <= bus_s2[7:0];
      end
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          wp   <= 5'h00;
          rp   <= 5'h00;
          cnt  <= 6'h00;
          lptr <= 4'h0;
        end else begin
          if (push_new)
            wp <= wp + 5'h01;
          if (pop)
            rp <= rp + 5'h01;
          cnt <= cnt + {5'h00, push_new} - {5'h00, pop};
          // one pointer walks labels for both writes and reads
          if (!ctrl_reg[`A4T_CB_LBL])
            lptr <= 4'h0;
          else if (lbl_mode && (rise[I_PL1 + i] || rise[I_RD1 + i]))
            lptr <= lptr + 4'h1;
        end
      end
      assign rdy[i] = (cnt != 6'h00);
      assign hlf[i] = (cnt >= `A4T_HALF_MARK);
      assign ful[i] = full;
      assign rxd[16 * i +: 16] = lbl_mode ? {8'h00, lbl[lptr]}
                               : map_half(mem[rp], sel,
                                          ctrl_reg[`A4T_CB_ORDER]);
    end
  endgenerate

  assign rx1_ready_n   = ~rdy[0];
  assign rx2_ready_n   = ~rdy[1];
  assign rx1_halfway_n = ~hlf[0];
  assign rx2_halfway_n = ~hlf[1];
  assign rx1_full_n    = ~ful[0];
  assign rx2_full_n    = ~ful[1];

  wire [8:0] link_fifo_condition;
  assign link_fifo_condition[`A4T_SB_TX_EMPTY] = (tcnt == 6'h00);
  assign link_fifo_condition[`A4T_SB_TX_FULL]  = t_full;
  assign link_fifo_condition[`A4T_SB_TX_HALF]  =
    (tcnt >= `A4T_HALF_MARK);
  assign link_fifo_condition[5:0] = {ful[1], hlf[1], rdy[1],
                                     ful[0], hlf[0], rdy[0]};
  assign tx_full_n    = ~t_full;
  assign tx_halfway_n = ~link_fifo_condition[`A4T_SB_TX_HALF];
  assign tx_done      = (tstate == TS_IDLE) & (tcnt == 6'h00);

  // bus read path; data registered, driven while a read strobe is low
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bus_out <= 16'h0000;
      bus_oe  <= 1'b0;
    end else begin
      bus_oe <= ~s2[I_RSR] | ~s2[I_RD1] | ~s2[I_RD1 + 1];
      if (!s2[I_RSR])
        bus_out <= sel ? ctrl_reg
                       : {7'h00, link_fifo_condition};
      else if (!s2[I_RD1])
        bus_out <= rxd[15:0];
      else if (!s2[I_RD1 + 1])
        bus_out <= rxd[31:16];
    end
  end

  // transmit FIFO: first half held until the second half arrives
  always @(posedge clk) begin
    if (t_push)
      tmem[twp] <= unmap(half1_reg, bus_s2, ctrl_reg[`A4T_CB_ORDER]);
  end
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      twp       <= 5'h00;
      trp       <= 5'h00;
      tcnt      <= 6'h00;
      half1_reg <= 16'h0000;
      half1_ok  <= 1'b0;
    end else begin
      if (rise[I_PL1] && !lbl_mode) begin
        half1_reg <= bus_s2;
        half1_ok  <= 1'b1;
      end else if (rise[I_PL1 + 1] && !lbl_mode) begin
        half1_ok  <= 1'b0;
      end
      if (t_push)
        twp <= twp + 5'h01;
      if (t_pop)
        trp <= trp + 5'h01;
      tcnt <= tcnt + {5'h00, t_push} - {5'h00, t_pop};
    end
  end

  // serializer; go only starts it, an empty FIFO stops it
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tstate       <= TS_IDLE;
      tsh          <= 32'h00000000;
      tbit         <= 5'h00;
      tphase       <= 6'h00;
      tx_ones_out  <= 1'b0;
      tx_zeros_out <= 1'b0;
    end else begin
      tx_ones_out  <= (tstate == TS_DATA) & tsh[0];
      tx_zeros_out <= (tstate == TS_DATA) & ~tsh[0];
      if (t_start) begin
        tsh    <= add_par(tmem[trp], ctrl_reg[`A4T_CB_PAR_ON],
                          ctrl_reg[`A4T_CB_PAR_EVEN]);
        tstate <= TS_DATA;
        tbit   <= 5'h00;
        tphase <= 6'h00;
      end else begin
        case (tstate)
          TS_IDLE: tphase <= 6'h00;
          TS_DATA: begin
            if (tx_en) begin
              tphase <= tphase + 6'h01;
              if (tphase == `A4T_TX_DATA - 6'h01) begin
                tstate <= TS_NULL;
                tphase <= 6'h00;
              end
            end
          end
          TS_NULL: begin
            if (tx_en) begin
              tphase <= tphase + 6'h01;
              if (tphase == `A4T_TX_NULL - 6'h01) begin
                tphase <= 6'h00;
                if (tbit == 5'h1f) begin
                  tstate <= TS_GAP;
                end else begin
                  tbit   <= tbit + 5'h01;
                  tsh    <= {1'b0, tsh[31:1]};
                  tstate <= TS_DATA;
                end
              end
            end
          end
          TS_GAP: begin
            if (tx_en) begin
              tphase <= tphase + 6'h01;
              if (tphase == `A4T_TX_GAP - 6'h01) begin
                tstate <= TS_IDLE;
                tphase <= 6'h00;
              end
            end
          end
          default: tstate <= TS_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> rtl/a4t_consts.vh
// constants for the dual receive, single transmit serial line core
// Operation
// - rx data-ready bit set while its FIFO holds words; ready pin is inverse.
// - rx half-full bit set at 16 or more words; half pin is inverse.
// - each rx FIFO holds 32 words; full bit and low full pin when 32.
// - a word arriving into a full rx FIFO overwrites the newest entry.
// - status bits 6,7,8 give tx empty, full, half; pins invert 7 and 8.
// - bit order one: first half serial bits 1-16, second half 17-32.
// - bit order zero: reversed label, 32, 30, 31, 9-13; second 14-29.
// - 10-sample shift registers; three equal samples; bit then null; gap nulls.
// - gap timer checks null every 10 samples; three nulls re-arm reception.
// - rate check rejects words whose bit spacing is outside 8 to 12 samples.
// - rate check off accepts any 32 bits but still needs the word gap.
// - ones counted including parity; odd count puts zero in bit 32.
// - word loaded only when enabled label and source filters both pass.
// - label filter compares bits 1-8 with 16 stored labels, any value.
// - label mode: 16 load pulses write labels, first strobe rx1, second rx2.
// - label mode: 16 reads return labels; host then clears label mode.
// - tx word is first half then second half; loads ignored when full.
// - tx parity on: bit 32 odd or even parity over 31 bits; off: data.
// - go high moves oldest word to shifter; first bit out within 2.5 clocks; low speed waits up to 8 clocks for a slow tick.
// - config strobe latches 16 bits; readable with half select one.
// - status read with half select zero on lines 0-8, rest zero.
// - tx bit 5 clocks, null 5, gap 40; low speed 40, 40, 320.
// - transmission runs until tx FIFO empty; done flag high when all sent.
`ifndef A4T_CONSTS_VH
`define A4T_CONSTS_VH
`define A4T_CLK_HZ       250000000
`define A4T_MCLK_HZ      1000000
`define A4T_TICK_DIV     (`A4T_CLK_HZ / `A4T_MCLK_HZ)
`define A4T_LO_LAST      3'h7
`define A4T_DEPTH        6'h20
`define A4T_HALF_MARK    6'h10
`define A4T_RATE_MIN     4'h8
`define A4T_RATE_MAX     4'hc
`define A4T_GAP_SAMPLES  4'ha
`define A4T_GAP_NULLS    2'h3
`define A4T_TX_DATA      6'h05
`define A4T_TX_NULL      6'h05
`define A4T_TX_GAP       6'h28
`define A4T_CTRL_RST     16'h0020
`define A4T_SYNC_RST     13'h1f90
`define A4T_CB_RX1_LO    0
`define A4T_CB_LBL       1
`define A4T_CB_LF1       2
`define A4T_CB_PAR_ON    4
`define A4T_CB_NOLOOP    5
`define A4T_CB_SF1       6
`define A4T_CB_SF2       9
`define A4T_CB_PAR_EVEN  12
`define A4T_CB_TX_LO     13
`define A4T_CB_RX2_LO    14
`define A4T_CB_ORDER     15
`define A4T_SB_TX_EMPTY  6
`define A4T_SB_TX_FULL   7
`define A4T_SB_TX_HALF   8
`endif

// >>> rtl/a4t_rx.v
// one serial receiver: sampling, bit timing, word gap and parity
`default_nettype none
`include "a4t_consts.vh"
module a4t_rx (
  input  wire        clk,
  input  wire        nrst,
  input  wire        samp_en,
  input  wire        rate_chk,
  input  wire        suspend,
  input  wire        one_in,
  input  wire        zero_in,
  output reg  [31:0] word_reg,
  output reg         word_stb_reg
);
  localparam ST_GAP  = 2'b01;
  localparam ST_WORD = 2'b10;
  reg  [9:0] one_sr;
  reg  [9:0] zero_sr;
  reg  [9:0] null_sr;
  reg        hit_d;
  reg  [3:0] spacing;
  reg  [4:0] bit_cnt;
  reg  [3:0] gap_tmr;
  reg  [1:0] gap_cnt;
  reg  [1:0] state;
  // oldest three samples hold the level, newest three are null
  wire one_hit  = (&one_sr[9:7]) & (&null_sr[2:0]);
  wire zero_hit = (&zero_sr[9:7]) & (&null_sr[2:0]);
  wire gap_null = (&null_sr[9:7]) & (&null_sr[2:0]);
  wire bit_ev   = samp_en & (one_hit | zero_hit) & ~hit_d;
  wire [3:0] spac_n = (spacing == 4'hf) ? spacing : spacing + 4'h1;
  wire rate_bad = rate_chk & (bit_cnt != 5'h00) &
                  ((spac_n < `A4T_RATE_MIN) | (spac_n > `A4T_RATE_MAX));

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      one_sr  <= 10'h000;
      zero_sr <= 10'h000;
      null_sr <= 10'h000;
      hit_d   <= 1'b0;
    end else if (samp_en) begin
      one_sr  <= {one_sr[8:0], one_in};
      zero_sr <= {zero_sr[8:0], zero_in};
      null_sr <= {null_sr[8:0], ~one_in & ~zero_in};
      hit_d   <= one_hit | zero_hit;
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_reg     <= 32'h00000000;
      word_stb_reg <= 1'b0;
      spacing      <= 4'h0;
      bit_cnt      <= 5'h00;
      gap_tmr      <= 4'h0;
      gap_cnt      <= 2'h0;
      state        <= ST_GAP;
    end else begin
      word_stb_reg <= 1'b0;
      case (state)
        ST_GAP: begin
          if (samp_en && !suspend) begin
            if (gap_tmr == `A4T_GAP_SAMPLES - 4'h1) begin
              gap_tmr <= 4'h0;
              if (gap_null) begin
                gap_cnt <= gap_cnt + 2'h1;
                if (gap_cnt == `A4T_GAP_NULLS - 2'h1) begin
                  state   <= ST_WORD;
                  bit_cnt <= 5'h00;
                  spacing <= 4'h0;
                end
              end
            end else begin
              gap_tmr <= gap_tmr + 4'h1;
            end
          end
        end
        ST_WORD: begin
          if (suspend) begin
            state   <= ST_GAP;
            gap_cnt <= 2'h0;
            gap_tmr <= 4'h0;
          end else if (bit_ev) begin
            spacing <= 4'h0;
            if (rate_bad) begin
              state   <= ST_GAP;
              gap_cnt <= 2'h0;
              gap_tmr <= 4'h0;
            end else begin
              word_reg[bit_cnt] <= one_hit;
              bit_cnt <= bit_cnt + 5'h01;
              if (bit_cnt == 5'h1f) begin
                // odd ones including the received parity give zero
                word_reg[31] <= ~(^{word_reg[30:0], one_hit});
                word_stb_reg <= 1'b1;
                state        <= ST_GAP;
                gap_cnt      <= 2'h0;
                gap_tmr      <= 4'h0;
              end
            end
          end else if (samp_en) begin
            spacing <= spac_n;
            // a stalled word is dropped only while rates are checked
            if (rate_chk && bit_cnt != 5'h00 &&
                spac_n > `A4T_RATE_MAX) begin
              state   <= ST_GAP;
              gap_cnt <= 2'h0;
              gap_tmr <= 4'h0;
            end
          end
        end
        default: state <= ST_GAP;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> verification/a4t_core_asserts.sv
// pin-level assertions for the serial line core
`default_nettype none
module a4t_core_asserts #(
  parameter int TICK_DIV = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reg_read_n,
  input wire logic rx1_read_n,
  input wire logic rx2_read_n,
  input wire logic bus_oe,
  input wire logic tx_go,
  input wire logic rx1_ready_n,
  input wire logic rx1_halfway_n,
  input wire logic rx1_full_n,
  input wire logic rx2_ready_n,
  input wire logic rx2_halfway_n,
  input wire logic rx2_full_n,
  input wire logic tx_full_n,
  input wire logic tx_halfway_n,
  input wire logic tx_done,
  input wire logic tx_ones_out,
  input wire logic tx_zeros_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // data bit lasts five tx ticks
  localparam int DHI = 5 * TICK_DIV - 1;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  AST_RX1_FULL: assert property (
    !rx1_full_n |-> !rx1_halfway_n && !rx1_ready_n)
    else $error("rx1 full without half or ready");
  AST_RX2_FULL: assert property (
    !rx2_full_n |-> !rx2_halfway_n && !rx2_ready_n)
    else $error("rx2 full without half or ready");
  AST_TX_FULL: assert property (
    !tx_full_n |-> !tx_halfway_n && !tx_done)
    else $error("tx full flags disagree");
  AST_TX_LEVEL: assert property (!(tx_ones_out && tx_zeros_out))
    else $error("tx one and zero both high");
  AST_TX_IDLE: assert property (
    tx_done |-> !tx_ones_out && !tx_zeros_out)
    else $error("tx active while done");
  AST_TX_BIT: assert property (
    $rose(tx_ones_out) |-> ##DHI tx_ones_out ##1 !tx_ones_out)
    else $error("tx data bit length wrong");
  AST_TX_START: assert property (
    $rose(tx_go) && !tx_done && !tx_ones_out && !tx_zeros_out
    |-> ##[1:16] (tx_ones_out || tx_zeros_out))
    else $error("tx first bit late");
  AST_OE_OFF: assert property (
    $rose(reg_read_n && rx1_read_n && rx2_read_n) |-> ##3 !bus_oe)
    else $error("bus not released");
  AST_OE_ON: assert property (
    $fell(reg_read_n && rx1_read_n && rx2_read_n) |-> ##3 bus_oe)
    else $error("bus not driven on read");
endmodule
`default_nettype wire

// >>> verification/a4t_line_src.sv
// serial line source for one receiver, null between bits and words
`default_nettype none
module a4t_line_src #(
  parameter int TICK_DIV = 4
) (
  input  wire logic clk,
  output var  logic one_out,
  output var  logic zero_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    one_out = 1'b0;
    zero_out = 1'b0;
  end
  // bit 1 goes first; line returns to null after every bit
  task automatic send(input logic [31:0] w);
    for (int i = 0; i < 32; i++) begin
      one_out <= w[i];
      zero_out <= !w[i];
      repeat (5 * TICK_DIV) @(posedge clk);
      one_out <= 1'b0;
      zero_out <= 1'b0;
      repeat (5 * TICK_DIV) @(posedge clk);
    end
    // generous gap so the receiver re-arms
    repeat (40 * TICK_DIV) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> verification/a4t_core_tb.sv
// self-checking bench for the serial line core
`default_nettype none
`define CHK(g, e) begin \
  logic [31:0] cg, ce; \
  cg = (g); \
  ce = (e); \
  samples_checked++; \
  if (cg !== ce) begin \
    fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, cg, ce); \
  end \
end
module a4t_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK_DIV = 4;
  logic        clk, nrst, half_sel, tx_go, rate_check_off_n;
  logic [5:0]  stb_n;
  logic [15:0] bus_in, bus_out;
  logic        bus_oe, r1o, r1z, r2o, r2z;
  logic        rx1_ready_n, rx1_halfway_n, rx1_full_n;
  logic        rx2_ready_n, rx2_halfway_n, rx2_full_n;
  logic        tx_full_n, tx_halfway_n, tx_done, tx_ones_out, tx_zeros_out;
  wire  [2:0]  p1 = {rx1_ready_n, rx1_halfway_n, rx1_full_n};
  wire  [2:0]  p2 = {rx2_ready_n, rx2_halfway_n, rx2_full_n};
  logic [31:0] seed = 32'h7f27;
  logic [31:0] q1[$], q2[$], qt[$];
  logic [7:0]  ql[$];
  int          fails, samples_checked;
  a4t_core #(.TICK_DIV(TICK_DIV)) dut (.clk(clk), .nrst(nrst),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe),
    .half_sel(half_sel), .reg_read_n(stb_n[0]), .rx1_read_n(stb_n[1]),
    .rx2_read_n(stb_n[2]), .ctrl_write_n(stb_n[3]),
    .load_first_half_n(stb_n[4]), .load_second_half_n(stb_n[5]),
    .tx_go(tx_go), .rate_check_off_n(rate_check_off_n),
    .rx1_one_in(r1o), .rx1_zero_in(r1z), .rx2_one_in(r2o),
    .rx2_zero_in(r2z), .rx1_ready_n(rx1_ready_n),
    .rx1_halfway_n(rx1_halfway_n), .rx1_full_n(rx1_full_n),
    .rx2_ready_n(rx2_ready_n), .rx2_halfway_n(rx2_halfway_n),
    .rx2_full_n(rx2_full_n), .tx_full_n(tx_full_n),
    .tx_halfway_n(tx_halfway_n), .tx_done(tx_done),
    .tx_ones_out(tx_ones_out), .tx_zeros_out(tx_zeros_out));
  a4t_line_src #(.TICK_DIV(TICK_DIV)) u_src1 (.clk(clk), .one_out(r1o),
    .zero_out(r1z));
  a4t_line_src #(.TICK_DIV(TICK_DIV)) u_src2 (.clk(clk), .one_out(r2o),
    .zero_out(r2z));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // receiver puts zero in bit 32 when the ones count is odd
  function automatic logic [31:0] rxw(logic [31:0] w);
    return {~^w, w[30:0]};
  endfunction
  // ready, half and full pins expected for a fill level
  function automatic logic [2:0] st(int s);
    return {s == 0, s < 16, s < 32};
  endfunction
  function automatic logic [31:0] map0(logic [31:0] w);
    return {w[28:13], w[12:8], w[30], w[29], w[31], w[0], w[1], w[2],
            w[3], w[4], w[5], w[6], w[7]};
  endfunction
  // a full fifo keeps its oldest words; the newest slot is replaced
  function automatic void push(ref logic [31:0] q[$], input logic [31:0] w);
    if (q.size() == 32) q[31] = w;
    else q.push_back(w);
  endfunction
  // strobe k low for four clocks, select and data set one clock ahead
  task automatic strobe(input int k, input logic sel, input logic [15:0] d,
                        output logic [15:0] q);
    half_sel <= sel;
    bus_in <= d;
    @(posedge clk);
    stb_n <= ~(6'h01 << k);
    repeat (4) @(posedge clk);
    q = bus_out;
    stb_n <= 6'h3f;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd_word(input int k, output logic [31:0] w);
    logic [15:0] a, b;
    strobe(k, 1'b0, 16'h0000, a);
    strobe(k, 1'b1, 16'h0000, b);
    w = {b, a};
  endtask
  task automatic print_verdict();
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // tx line monitor: one bit per rise of either output, bit 1 first
  initial begin
    logic [31:0] tw;
    logic        pv;
    int          k;
    k = 0;
    pv = 1'b0;
    forever begin
      @(posedge clk);
      if ((tx_ones_out | tx_zeros_out) && !pv) begin
        tw[k] = tx_ones_out;
        k++;
        if (k == 32) begin
          k = 0;
          `CHK(tw, qt.pop_front())
        end
      end
      pv = tx_ones_out | tx_zeros_out;
    end
  end
  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    print_verdict();
  end
  initial begin
    logic [15:0] a;
    logic [31:0] w1, w2;
    int n;
    nrst = 1'b0;
    half_sel = 1'b0;
    tx_go = 1'b0;
    rate_check_off_n = 1'b1;
    stb_n = 6'h3f;
    bus_in = 16'h0000;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    strobe(0, 1'b0, 16'h0000, a);
    `CHK(a, 16'h0040)
    // order one, no loopback, odd tx parity, rx1 sdi wants bits 9,10 = 1,0
    strobe(3, 1'b0, 16'h80f0, a);
    strobe(0, 1'b1, 16'h0000, a);
    `CHK(a, 16'h80f0)
    for (n = 1; n <= 33; n++) begin
      w1 = xs();
      if (n <= 32) qt.push_back({~^w1[30:0], w1[30:0]});
      strobe(4, 1'b0, w1[15:0], a);
      strobe(5, 1'b0, w1[31:16], a);
      `CHK({tx_full_n, tx_halfway_n}, {n < 32, n < 16})
    end
    strobe(0, 1'b0, 16'h0000, a);
    `CHK(a, 16'h0180)
    tx_go <= 1'b1;
    for (n = 0; n < 33; n++) begin
      w1 = xs();
      w2 = xs();
      if (!n[0]) w1[9:8] = 2'b01;
      fork
        u_src1.send(w1);
        u_src2.send(w2);
      join
      if (w1[9:8] == 2'b01) push(q1, rxw(w1));
      push(q2, rxw(w2));
      `CHK(p2, st(q2.size()))
      `CHK(p1, st(q1.size()))
    end
    while (q2.size() > 0) begin
      rd_word(2, w2);
      `CHK(w2, q2.pop_front())
    end
    `CHK(rx2_ready_n, 1'b1)
    strobe(3, 1'b0, 16'h00f0, a);
    while (q1.size() > 0) begin
      rd_word(1, w1);
      `CHK(w1, map0(q1.pop_front()))
    end
    `CHK(rx1_ready_n, 1'b1)
    for (n = 0; n < 60000 && tx_done !== 1'b1; n++) @(posedge clk);
    `CHK(tx_done, 1'b1)
    `CHK(qt.size(), 0)
    strobe(0, 1'b0, 16'h0000, a);
    `CHK(a, 16'h0040)
    // label mode: 16 writes for rx1, then 16 reads give them back
    strobe(3, 1'b0, 16'h00f2, a);
    for (n = 0; n < 16; n++) begin
      w1 = xs();
      ql.push_back(w1[7:0]);
      strobe(4, 1'b1, w1[15:0], a);
    end
    for (n = 0; n < 16; n++) begin
      strobe(1, 1'b1, 16'h0000, a);
      `CHK(a, {8'h00, ql.pop_front()})
    end
    strobe(3, 1'b0, 16'h00f0, a);
    print_verdict();
  end
endmodule
bind a4t_core a4t_core_asserts #(.TICK_DIV(TICK_DIV)) u_chk (.clk(clk),
  .nrst(nrst), .reg_read_n(reg_read_n), .rx1_read_n(rx1_read_n),
  .rx2_read_n(rx2_read_n), .bus_oe(bus_oe), .tx_go(tx_go),
  .rx1_ready_n(rx1_ready_n), .rx1_halfway_n(rx1_halfway_n),
  .rx1_full_n(rx1_full_n), .rx2_ready_n(rx2_ready_n),
  .rx2_halfway_n(rx2_halfway_n), .rx2_full_n(rx2_full_n),
  .tx_full_n(tx_full_n), .tx_halfway_n(tx_halfway_n), .tx_done(tx_done),
  .tx_ones_out(tx_ones_out), .tx_zeros_out(tx_zeros_out));
`default_nettype wire
